// ---- verilog/pstfc_pkg.sv ----
`default_nettype none
package pstfc_pkg;
    localparam logic [7:0] ADDR_SECONDARY_TIMEBASE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_FCL = 8'h04;
    localparam logic [7:0] ADDR_STRIG = 8'h08;
    localparam logic [7:0] ADDR_PER = 8'h0C;
    localparam logic [7:0] ADDR_MISC = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_CNT = 8'h18;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [15:0] SECONDARY_TIMEBASE_CONTROL_WMASK = 16'h0FFF;
    localparam logic [15:0] STRIG_MASK = 16'hFFF8;
    localparam logic [15:0] MISC_MASK = 16'h003F;
    localparam int ST_PEND = 12;
    localparam int ST_IEN = 11;
    localparam int ST_IPU = 10;
    localparam int ST_SPOL = 9;
    localparam int ST_SOEN = 8;
    localparam int ST_SEN = 7;
    localparam int ST_SSRC = 4;
    localparam int ST_PS = 0;
    localparam int FC_IND = 15;
    localparam int FC_CLSRC = 10;
    localparam int FC_LIMIT_POLARITY = 9;
    localparam int FC_LIMIT_MODE_ENABLE = 8;
    localparam int FC_FSRC = 3;
    localparam int FC_FPOL = 2;
    localparam int FC_FMOD = 0;
    localparam int STRIG_LSB = 3;
    localparam int MI_TBEN = 0;
    localparam int MI_LOCAL = 1;
    localparam int MI_FDAT_L = 2;
    localparam int MI_FDAT_H = 3;
    localparam int MI_CDAT_L = 4;
    localparam int MI_CDAT_H = 5;
    localparam int SA_LATCHED = 0;
    localparam int SA_FAULT = 1;
    localparam int SA_LIMIT = 2;
    localparam logic [2:0] SYNC_SRC1 = 3'h0;
    localparam logic [2:0] SYNC_SRC2 = 3'h1;
    localparam logic [2:0] SYNC_SRC3 = 3'h2;
    localparam logic [4:0] CMP_LAST = 5'h03;
    localparam logic [4:0] FLT_FIRST = 5'h08;
    localparam logic [4:0] FLT_LAST = 5'h1E;
    localparam logic [1:0] FMOD_LATCH = 2'h0;
    localparam logic [1:0] FMOD_CYCLE = 2'h1;
    localparam logic [1:0] FMOD_RSVD = 2'h2;
    localparam logic [1:0] FMOD_OFF = 2'h3;
    typedef enum logic [1:0] {
        PSTFC_FLT_IDLE = 2'h0,
        PSTFC_FLT_CYCLE = 2'h1,
        PSTFC_FLT_LATCH = 2'h3
    } pstfc_flt_state_t;
endpackage
`default_nettype wire

// ---- verilog/pstfc_sel_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pstfc_sel_if;
    logic [4:0] code;
    logic invert;
    logic active;
    modport ctrl (output code, output invert, input active);
    modport sel (input code, input invert, output active);
endinterface
`default_nettype wire

// ---- verilog/pstfc_src_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module pstfc_src_sel #(
    parameter int N_CMP = 4,
    parameter int N_FLT = 23
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pstfc_sel_if.sel sel,
    input wire logic [N_CMP-1:0] comparator_i,
    input wire logic [N_FLT-1:0] fault_i
);
    import pstfc_pkg::*;
    if (N_CMP != 4 || N_FLT != 23) begin : g_bad
        $error("source selector serves 4 comparators and 23 fault inputs");
    end
    logic raw;
    logic valid;
    logic [4:0] idx;
    always_comb begin
        idx = sel.code - FLT_FIRST;
        raw = 1'b0;
        valid = 1'b0;
        if (sel.code <= CMP_LAST) begin
            raw = comparator_i[sel.code[1:0]];
            valid = 1'b1;
        end else if (sel.code >= FLT_FIRST && sel.code <= FLT_LAST) begin
            raw = fault_i[idx];
            valid = 1'b1;
        end
    end
    // reserved codes never assert, whatever the polarity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel.active <= 1'b0;
        end else begin
            sel.active <= valid & (raw ^ sel.invert);
        end
    end
    rsvd_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) !valid |=> !sel.active)
        else $error("reserved source code asserted");
    pol_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid |=> sel.active == ($past(raw) ^ $past(sel.invert)))
        else $error("selected source polarity not applied");
endmodule // pstfc_src_sel
`default_nettype wire

// ---- verilog/pstfc_postscale.sv ----
`timescale 1ns/1ps
`default_nettype none
module pstfc_postscale #(
    parameter int PS_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic event_i,
    input wire logic [PS_W-1:0] ratio_i,
    output logic event_o
);
    if (PS_W < 1) begin : g_bad
        $error("postscaler needs at least one bit");
    end
    logic [PS_W-1:0] cnt_reg;
    // >= so a ratio lowered mid-count still fires promptly
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            event_o <= 1'b0;
        end else begin
            event_o <= 1'b0;
            if (event_i) begin
                if (cnt_reg >= ratio_i) begin
                    cnt_reg <= '0;
                    event_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
    ps_one_a: assert property (@(posedge clk_i) disable iff (rst_i) event_i && ratio_i == '0 |=> event_o)
        else $error("one to one postscale missed an event");
endmodule // pstfc_postscale
`default_nettype wire

// ---- verilog/pstfc_top.sv ----
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pstfc_top #(
    parameter int PER_W = 16,
    parameter int N_CMP = 4,
    parameter int N_FLT = 23
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sync_input_1_i,
    input wire logic sync_input_2_i,
    input wire logic sync_input_3_i,
    output logic sec_sync_output_o,
    output logic sec_sync_output_oe_o,
    input wire logic [N_CMP-1:0] comparator_i,
    input wire logic [N_FLT-1:0] fault_inputs_i,
    input wire logic pwm_high_i,
    input wire logic pwm_low_i,
    output logic high_side_output_o,
    output logic low_side_output_o,
    input wire logic irq_ack_i,
    output logic sec_event_irq_o,
    output logic event_trigger_o,
    output logic adc_trigger_o
);
    import pstfc_pkg::*;

    if (PER_W != 16) begin : g_bad
        $error("time base must be 16 bits to match the trigger compare layout");
    end

    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        wmerge = (old & ~m) | (dat[15:0] & m);
    endfunction

    function automatic logic sync_pick(input logic [2:0] src, input logic a, input logic b,
                                       input logic c);
        case (src)
            SYNC_SRC1: sync_pick = a;
            SYNC_SRC2: sync_pick = b;
            SYNC_SRC3: sync_pick = c;
            default: sync_pick = 1'b0;
        endcase
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic ack_reg;
    logic [11:0] st_ctrl_reg;
    logic st_pend_reg;
    logic [15:0] fcl_reg;
    logic [12:0] strig_reg;
    logic [PER_W-1:0] per_buf_reg;
    logic [PER_W-1:0] per_active_reg;
    logic per_pend_reg;
    logic [5:0] misc_reg;
    logic [PER_W-1:0] cnt_reg;
    logic sync_prev_reg;
    pstfc_flt_state_t flt_state_reg;
    pstfc_flt_state_t flt_state_next;
    logic bus_req;
    logic wr_en;
    logic [15:0] st_rd;
    logic tben;
    logic boundary;
    logic sync_level;
    logic sync_evt;
    logic ps_evt;
    logic flt_clear;
    logic [1:0] fmod;
    logic fault_force;
    logic limit_force;
    logic [15:0] cmp_value;
    logic [15:0] st_wr;
    logic [15:0] strig_wr;
    logic [15:0] misc_wr;

    pstfc_sel_if flt_if ();
    pstfc_sel_if lim_if ();

    assign bus_req = wb_cyc_i & wb_stb_i;
    // write lands on the edge where the master samples ack
    assign wr_en = bus_req & wb_we_i & ack_reg;
    assign wb_ack_o = ack_reg;
    assign st_rd = {3'h0, st_pend_reg, st_ctrl_reg};
    assign tben = misc_reg[MI_TBEN];
    assign fmod = fcl_reg[FC_FMOD +: 2];
    assign cmp_value = {strig_reg, 3'h0};
    assign st_wr = wmerge(st_rd, wb_dat_i, wb_sel_i, SECONDARY_TIMEBASE_CONTROL_WMASK);
    assign strig_wr = wmerge(cmp_value, wb_dat_i, wb_sel_i, STRIG_MASK);
    assign misc_wr = wmerge({10'h000, misc_reg}, wb_dat_i, wb_sel_i, MISC_MASK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req & ~ack_reg) begin
            case (wb_adr_i)
                ADDR_SECONDARY_TIMEBASE_CONTROL: wb_dat_o <= {16'h0000, st_rd};
                ADDR_FCL: wb_dat_o <= {16'h0000, fcl_reg};
                ADDR_STRIG: wb_dat_o <= {16'h0000, cmp_value};
                ADDR_PER: wb_dat_o <= {16'h0000, per_buf_reg};
                ADDR_MISC: wb_dat_o <= {26'h0000000, misc_reg};
                ADDR_STAT: wb_dat_o <= {29'h00000000, limit_force, fault_force,
                                        flt_state_reg == PSTFC_FLT_LATCH};
                ADDR_CNT: wb_dat_o <= {16'h0000, cnt_reg};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ctrl_reg <= REG_RST[11:0];
            fcl_reg <= REG_RST;
            strig_reg <= REG_RST[12:0];
            per_buf_reg <= REG_RST;
            misc_reg <= REG_RST[5:0];
        end else if (wr_en) begin
            case (wb_adr_i)
                ADDR_SECONDARY_TIMEBASE_CONTROL: st_ctrl_reg <= st_wr[11:0];
                // polarity changes are trusted to come while the time base is stopped
                ADDR_FCL: fcl_reg <= wmerge(fcl_reg, wb_dat_i, wb_sel_i, 16'hFFFF);
                ADDR_STRIG: strig_reg <= strig_wr[15:STRIG_LSB];
                ADDR_PER: per_buf_reg <= wmerge(per_buf_reg, wb_dat_i, wb_sel_i, 16'hFFFF);
                ADDR_MISC: misc_reg <= misc_wr[5:0];
                default: ;
            endcase
        end
    end

    // period buffer: a write and a load in one cycle keep the pending flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_pend_reg <= 1'b0;
            per_active_reg <= REG_RST;
        end else begin
            if (per_pend_reg && (st_ctrl_reg[ST_IPU] || boundary)) begin
                per_active_reg <= per_buf_reg;
            end
            if (wr_en && wb_adr_i == ADDR_PER && wb_sel_i[1:0] != 2'h0) begin
                per_pend_reg <= 1'b1;
            end else if (st_ctrl_reg[ST_IPU] || boundary) begin
                per_pend_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        sync_level = sync_pick(st_ctrl_reg[ST_SSRC +: 3], sync_input_1_i, sync_input_2_i,
                               sync_input_3_i) ^ st_ctrl_reg[ST_SPOL];
        sync_evt = st_ctrl_reg[ST_SEN] & sync_level & ~sync_prev_reg;
        boundary = tben & (cnt_reg >= per_active_reg);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_prev_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            sync_prev_reg <= sync_level;
            if (!tben || sync_evt || boundary) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_sync_output_o <= 1'b0;
            sec_sync_output_oe_o <= 1'b0;
        end else begin
            sec_sync_output_oe_o <= st_ctrl_reg[ST_SOEN];
            sec_sync_output_o <= st_ctrl_reg[ST_SOEN] & (boundary ^ st_ctrl_reg[ST_SPOL]);
        end
    end

    pstfc_postscale #(
        .PS_W(4)
    ) u_ps (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(boundary),
        .ratio_i(st_ctrl_reg[ST_PS +: 4]),
        .event_o(ps_evt)
    );
    assign event_trigger_o = ps_evt;

    // set wins over the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_pend_reg <= 1'b0;
        end else if (ps_evt) begin
            st_pend_reg <= 1'b1;
        end else if (irq_ack_i) begin
            st_pend_reg <= 1'b0;
        end
    end
    assign sec_event_irq_o = st_pend_reg & st_ctrl_reg[ST_IEN];

    // converter trigger only; nothing here feeds an interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_trigger_o <= 1'b0;
        end else begin
            adc_trigger_o <= tben & misc_reg[MI_LOCAL] & (cnt_reg == cmp_value);
        end
    end

    assign flt_if.code = fcl_reg[FC_FSRC +: 5];
    assign flt_if.invert = fcl_reg[FC_FPOL];
    assign lim_if.code = fcl_reg[FC_CLSRC +: 5];
    assign lim_if.invert = fcl_reg[FC_LIMIT_POLARITY];

    pstfc_src_sel #(
        .N_CMP(N_CMP),
        .N_FLT(N_FLT)
    ) u_flt_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel(flt_if.sel),
        .comparator_i(comparator_i),
        .fault_i(fault_inputs_i)
    );

    pstfc_src_sel #(
        .N_CMP(N_CMP),
        .N_FLT(N_FLT)
    ) u_lim_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel(lim_if.sel),
        .comparator_i(comparator_i),
        .fault_i(fault_inputs_i)
    );

    assign flt_clear = wr_en && wb_adr_i == ADDR_STAT && wb_sel_i[0] && wb_dat_i[SA_LATCHED];

    always_comb begin
        flt_state_next = flt_state_reg;
        case (flt_state_reg)
            PSTFC_FLT_IDLE: begin
                if (flt_if.active && fmod == FMOD_LATCH) begin
                    flt_state_next = PSTFC_FLT_LATCH;
                end else if (flt_if.active && fmod == FMOD_CYCLE) begin
                    flt_state_next = PSTFC_FLT_CYCLE;
                end
            end
            PSTFC_FLT_CYCLE: begin
                // release with the source quiet, at a cycle boundary or while the time base is stopped
                if (!flt_if.active && (boundary || !tben)) begin
                    flt_state_next = PSTFC_FLT_IDLE;
                end
            end
            PSTFC_FLT_LATCH: begin
                if (flt_clear && !flt_if.active) begin
                    flt_state_next = PSTFC_FLT_IDLE;
                end
            end
            default: flt_state_next = PSTFC_FLT_IDLE;
        endcase
        if (fmod == FMOD_OFF || fmod == FMOD_RSVD) begin
            flt_state_next = PSTFC_FLT_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_state_reg <= PSTFC_FLT_IDLE;
        end else begin
            flt_state_reg <= flt_state_next;
        end
    end

    assign fault_force = flt_state_reg != PSTFC_FLT_IDLE;
    assign limit_force = fcl_reg[FC_LIMIT_MODE_ENABLE] & lim_if.active;

    // independent mode: limit owns the high side, fault the low side;
    // software keeps the two selects apart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_side_output_o <= 1'b0;
            low_side_output_o <= 1'b0;
        end else if (fcl_reg[FC_IND]) begin
            high_side_output_o <= limit_force ? misc_reg[MI_CDAT_H] : pwm_high_i;
            low_side_output_o <= fault_force ? misc_reg[MI_FDAT_L] : pwm_low_i;
        end else if (fault_force) begin
            high_side_output_o <= misc_reg[MI_FDAT_H];
            low_side_output_o <= misc_reg[MI_FDAT_L];
        end else if (limit_force) begin
            high_side_output_o <= misc_reg[MI_CDAT_H];
            low_side_output_o <= misc_reg[MI_CDAT_L];
        end else begin
            high_side_output_o <= pwm_high_i;
            low_side_output_o <= pwm_low_i;
        end
    end

    pend_set_a: assert property (ps_evt |=> st_pend_reg)
        else $error("event pending flag not set by a special event");
    pend_clr_a: assert property (irq_ack_i && !ps_evt |=> !st_pend_reg)
        else $error("event pending flag not cleared by acknowledge");
    irq_gate_a: assert property (ps_evt && !irq_ack_i |=> sec_event_irq_o == st_ctrl_reg[ST_IEN])
        else $error("event interrupt does not follow its enable");
    imm_load_a: assert property (per_pend_reg && st_ctrl_reg[ST_IPU] |=> per_active_reg == $past(per_buf_reg))
        else $error("immediate period update missed");
    wait_load_a: assert property (!st_ctrl_reg[ST_IPU] && !boundary |=> $stable(per_active_reg))
        else $error("period changed away from a cycle boundary");
    sync_pol_a: assert property (st_ctrl_reg[ST_SOEN] && !boundary |=> sec_sync_output_o == $past(st_ctrl_reg[ST_SPOL]))
        else $error("sync output idle level wrong");
    sync_off_a: assert property (!st_ctrl_reg[ST_SOEN] |=> !sec_sync_output_oe_o && !sec_sync_output_o)
        else $error("sync output driven while disabled");
    ext_sync_a: assert property (sync_evt |=> cnt_reg == '0)
        else $error("time base not resynchronised");
    no_sync_a: assert property (tben && !st_ctrl_reg[ST_SEN] && !boundary |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("time base disturbed without sync enabled");
    trig_post_a: assert property (event_trigger_o |-> $past(boundary))
        else $error("event trigger without a cycle boundary");
    limit_drive_a: assert property (limit_force && !fault_force && !fcl_reg[FC_IND] |=> high_side_output_o == $past(misc_reg[MI_CDAT_H]))
        else $error("limit override not applied");
    fault_off_a: assert property (fmod == FMOD_OFF |=> flt_state_reg == PSTFC_FLT_IDLE)
        else $error("fault acted while disabled");
    latch_hold_a: assert property (flt_state_reg == PSTFC_FLT_LATCH && !flt_clear && fmod == FMOD_LATCH |=> flt_state_reg == PSTFC_FLT_LATCH)
        else $error("latched fault released without clear");
    adc_match_a: assert property (adc_trigger_o |-> $past(cnt_reg[2:0]) == 3'h0 && $past(misc_reg[MI_LOCAL]))
        else $error("converter trigger without a compare match");
    reset_zero_a: assert property ($past(rst_i) |-> st_ctrl_reg == '0 && fcl_reg == '0 && strig_reg == '0)
        else $error("control bits not zero after reset");

    event_irq_c: cover property (ps_evt && st_ctrl_reg[ST_IEN]);
    latch_fault_c: cover property (flt_state_reg == PSTFC_FLT_LATCH ##1 flt_state_reg == PSTFC_FLT_IDLE);
    ext_sync_c: cover property (sync_evt && cnt_reg != '0);
    adc_trig_c: cover property (adc_trigger_o);
endmodule // pstfc_top
`default_nettype wire

// ---- bench/pstfc_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pstfc_stage_model (
    input wire logic clk_i,
    input wire logic [3:0] cmp_set_i,
    input wire logic [22:0] flt_set_i,
    input wire logic [2:0] sync_set_i,
    output logic [3:0] comparator_o,
    output logic [22:0] fault_o,
    output logic [2:0] sync_o,
    output logic pwm_high_o,
    output logic pwm_low_o
);
    // levels change only just after an edge, like a real comparator bank
    always_ff @(posedge clk_i) begin
        comparator_o <= cmp_set_i;
        fault_o <= flt_set_i;
        sync_o <= sync_set_i;
    end
    // raw generator held at high=1 low=0 so any override is visible
    always_ff @(posedge clk_i) begin
        pwm_high_o <= 1'b1;
        pwm_low_o <= 1'b0;
    end
endmodule // pstfc_stage_model
`default_nettype wire

// ---- bench/pstfc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pstfc_top_tb;
import pstfc_pkg::*;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cs = 1'b0;
logic we = 1'b0;
logic [7:0] adr = 8'h00;
logic [31:0] dat = 32'h0;
logic [3:0] cmp_set = 4'h0;
logic [22:0] flt_set = 23'h0;
logic [2:0] sync_set = 3'h0;
logic irq_ack = 1'b0;
logic [31:0] rdat;
logic ack, sso, ssoe, hi, lo, irq, evt, adc, ph, pl;
logic [3:0] cmp;
logic [22:0] flt;
logic [2:0] syn;
logic [15:0] q;
logic [7:0] regs [3] = '{ADDR_SECONDARY_TIMEBASE_CONTROL, ADDR_FCL, ADDR_STRIG};
int ps [4] = '{0, 1, 3, 15};
int bad_count = 0;
int checks = 0;
int g;
always #2.5 clk_i = ~clk_i;
pstfc_stage_model model (.clk_i(clk_i), .cmp_set_i(cmp_set), .flt_set_i(flt_set), .sync_set_i(sync_set),
    .comparator_o(cmp), .fault_o(flt), .sync_o(syn), .pwm_high_o(ph), .pwm_low_o(pl));
pstfc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_input_1_i(syn[0]), .sync_input_2_i(syn[1]), .sync_input_3_i(syn[2]),
    .sec_sync_output_o(sso), .sec_sync_output_oe_o(ssoe), .comparator_i(cmp), .fault_inputs_i(flt),
    .pwm_high_i(ph), .pwm_low_i(pl), .high_side_output_o(hi), .low_side_output_o(lo),
    .irq_ack_i(irq_ack), .sec_event_irq_o(irq), .event_trigger_o(evt), .adc_trigger_o(adc));
task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", n, e, s);
    end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    n = 0;
    do begin
        @(posedge clk_i);
        n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
        bad_count++;
        $display("[ERR] ack expected 1 seen 0");
    end
    q = rdat[15:0];
    cs <= 1'b0;
    we <= 1'b0;
endtask
// settle time covers selector, state and output registers
task automatic fstep(input logic [15:0] f, input logic [1:0] e);
    wb(1'b1, ADDR_FCL, f);
    repeat (6) @(posedge clk_i);
    chk("outputs", {14'h0, e}, {14'h0, hi, lo});
endtask
task automatic gap(input bit a, output int n);
    int w;
    w = 0;
    @(posedge clk_i);
    while ((a ? adc : evt) !== 1'b1 && w < 200) begin
        @(posedge clk_i);
        w++;
    end
    n = 0;
    do begin
        @(posedge clk_i);
        n++;
    end while ((a ? adc : evt) !== 1'b1 && n < 200);
endtask
task automatic stop_test;
    $display("errors=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test;
end
initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
        wb(1'b0, regs[i], 16'h0);
        chk("reset value", REG_RST, q);
    end
    wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'hFFFF);
    wb(1'b0, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0);
    chk("secondary_timebase_control", 16'h0FFF, q);
    chk("sync oe on", 16'h1, {15'h0, ssoe});
    chk("sync out idle", 16'h1, {15'h0, sso});
    wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0);
    repeat (2) @(posedge clk_i);
    chk("sync oe off", 16'h0, {15'h0, ssoe});
    chk("sync out off", 16'h0, {15'h0, sso});
    wb(1'b1, ADDR_STRIG, 16'hFFFF);
    wb(1'b0, ADDR_STRIG, 16'h0);
    chk("strig", 16'hFFF8, q);
    wb(1'b1, 8'h20, 16'hFFFF);
    wb(1'b0, 8'h20, 16'h0);
    chk("unmapped", 16'h0, q);
    // polarity edits only while the time base is stopped
    wb(1'b1, ADDR_MISC, 16'h0014);
    flt_set <= 23'h1;
    fstep(16'h0040, 2'b01);
    flt_set <= 23'h0;
    fstep(16'h0040, 2'b01);
    wb(1'b1, ADDR_STAT, 16'h0001);
    repeat (6) @(posedge clk_i);
    chk("latch release", 16'h2, {14'h0, hi, lo});
    fstep(16'h0045, 2'b01);
    flt_set <= 23'h1;
    fstep(16'h0045, 2'b10);
    fstep(16'h0043, 2'b10);
    flt_set <= 23'h0;
    cmp_set <= 4'h1;
    fstep(16'h0043, 2'b10);
    fstep(16'h0143, 2'b01);
    fstep(16'h0343, 2'b10);
    cmp_set <= 4'h0;
    fstep(16'h0343, 2'b01);
    cmp_set <= 4'h1;
    fstep(16'h8149, 2'b00);
    cmp_set <= 4'h0;
    flt_set <= 23'h2;
    fstep(16'h8149, 2'b11);
    flt_set <= 23'h0;
    fstep(16'h0043, 2'b10);
    wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0400);
    wb(1'b1, ADDR_PER, 16'h0002);
    wb(1'b1, ADDR_MISC, 16'h0015);
    for (int i = 0; i < 4; i++) begin
        wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0400 | 16'(ps[i]));
        gap(1'b0, g);
        gap(1'b0, g);
        chk("event gap", 16'(3 * (ps[i] + 1)), g[15:0]);
    end
    wb(1'b0, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0);
    chk("pending", 16'h140F, q);
    chk("irq masked", 16'h0, {15'h0, irq});
    wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0C0F);
    @(posedge clk_i);
    chk("irq enabled", 16'h1, {15'h0, irq});
    // acknowledge right after an event, well before the next one
    gap(1'b0, g);
    irq_ack <= 1'b1;
    @(posedge clk_i);
    irq_ack <= 1'b0;
    @(posedge clk_i);
    chk("irq cleared", 16'h0, {15'h0, irq});
    wb(1'b1, ADDR_STRIG, 16'h0008);
    wb(1'b1, ADDR_PER, 16'h0008);
    wb(1'b1, ADDR_MISC, 16'h0017);
    gap(1'b1, g);
    gap(1'b1, g);
    chk("adc gap", 16'h9, g[15:0]);
    // sync edge just after a compare match: counter reads 0 instead of 3
    wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0090);
    for (int i = 0; i < 2; i++) begin
        gap(1'b1, g);
        sync_set <= (i == 0) ? 3'h2 : 3'h0;
        @(posedge clk_i);
        wb(1'b0, ADDR_CNT, 16'h0);
        chk("sync restart", 16'h0, q);
        chk("sync out", 16'(i), {15'h0, sso});
        wb(1'b1, ADDR_SECONDARY_TIMEBASE_CONTROL, 16'h0390);
    end
    stop_test;
end
endmodule // pstfc_top_tb
`default_nettype wire
